// *** accumulator_rotate_bitset_unit.sv ***
// Purpose: executes accumulator rotates and the set-bit instruction
// Assumes: decoder presents one opcode per machine cycle with execValid
// Notes: direct-bit set is handed out as a one-cycle write pulse
`timescale 1ns/1ns
// Summary of operation
// - opcode 0x23 rotates the accumulator left with bit 7 into bit 0 in one cycle.
// - plain left and right rotates leave carry and every other flag unchanged.
// - opcode 0x33 rotates accumulator and carry left as a nine-bit ring.
// - plain right rotate moves bits down and bit 0 into bit 7 in one cycle.
// - opcode 0x13 moves bit 0 into carry and shifts the other bits down.
// - right rotate through carry puts the old carry into bit 7, other flags untouched.
// - set-bit forces carry or the addressed bit to one and alters no other flag.
module accumulator_rotate_bitset_unit (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// instruction from the decoder
	input wire logic execValid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] bitAddr,
	// architectural state
	output logic [7:0] acc,
	output logic carry,
	// direct-bit write towards the bit-addressable space
	output logic bitWrite,
	output logic [7:0] bitWriteAddr,
	output logic bitWriteData,
	// completion
	output logic execDone
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic isLeft;
	wire logic isLeftC;
	wire logic isRight;
	wire logic isRightC;
	wire logic isSetC;
	wire logic isSetBit;
	wire logic isRotate;
	wire logic [7:0] rotAcc;
	wire logic rotCarry;
	logic [7:0] next_acc;
	logic next_carry;

	assign isLeft = execValid && opcode == rot_bitset_pkg::OPC_ROTATE_ACC_LEFT;
	assign isLeftC = execValid && opcode == rot_bitset_pkg::OPC_ROTATE_ACC_LEFT_THRU_CARRY;
	assign isRight = execValid && opcode == rot_bitset_pkg::OPC_ROTATE_ACC_RIGHT;
	assign isRightC = execValid && opcode == rot_bitset_pkg::OPC_ROTATE_ACC_RIGHT_THRU_CARRY;
	assign isSetC = execValid && opcode == rot_bitset_pkg::OPC_SET_BIT_OP_CARRY;
	assign isSetBit = execValid && opcode == rot_bitset_pkg::OPC_SET_BIT_OP_BIT;
	assign isRotate = isLeft || isLeftC || isRight || isRightC;

	rot_shift_core u_rot (
		.accIn(acc),
		.carryIn(carry),
		.dirRight(isRight || isRightC),
		.thruCarry(isLeftC || isRightC),
		.accOut(rotAcc),
		.carryOut(rotCarry)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// carry only moves for the through-carry forms and set carry; plain rotates keep it
	assign next_acc = isRotate ? rotAcc : acc;
	assign next_carry = isSetC ? 1'b1 : (isRotate ? rotCarry : carry);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc <= rot_bitset_pkg::ACC_RESET;
			carry <= rot_bitset_pkg::CARRY_RESET;
			bitWrite <= 1'b0;
			bitWriteAddr <= rot_bitset_pkg::BIT_ADDR_RESET;
			bitWriteData <= 1'b0;
			execDone <= 1'b0;
		end else begin
			acc <= next_acc;
			carry <= next_carry;
			bitWrite <= isSetBit;
			if (isSetBit) begin
				bitWriteAddr <= bitAddr;
			end
			bitWriteData <= isSetBit;
			execDone <= isRotate || isSetC || isSetBit;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_left;
		@(posedge clock) disable iff (!arst_n)
		isLeft |=> acc == {$past(acc[6:0]), $past(acc[7])} && execDone;
	endproperty
	a_left: assert property (p_left) else $error("left rotate wrong");

	property p_plain_carry;
		@(posedge clock) disable iff (!arst_n)
		(isLeft || isRight) |=> carry == $past(carry);
	endproperty
	a_plain_carry: assert property (p_plain_carry) else $error("carry moved");

	property p_leftc;
		@(posedge clock) disable iff (!arst_n)
		isLeftC |=> {carry, acc} == {$past(acc), $past(carry)};
	endproperty
	a_leftc: assert property (p_leftc) else $error("left thru carry wrong");

	property p_right;
		@(posedge clock) disable iff (!arst_n)
		isRight |=> acc == {$past(acc[0]), $past(acc[7:1])};
	endproperty
	a_right: assert property (p_right) else $error("right rotate wrong");

	property p_rightc_carry;
		@(posedge clock) disable iff (!arst_n)
		isRightC |=> carry == $past(acc[0]) && acc[6:0] == $past(acc[7:1]);
	endproperty
	a_rightc_carry: assert property (p_rightc_carry) else $error("right carry wrong");

	property p_rightc_top;
		@(posedge clock) disable iff (!arst_n)
		isRightC |=> acc[7] == $past(carry);
	endproperty
	a_rightc_top: assert property (p_rightc_top) else $error("bit 7 not old carry");

	property p_set_bit_op;
		@(posedge clock) disable iff (!arst_n)
		isSetC |=> carry && $stable(acc) && !bitWrite;
	endproperty
	a_set_bit_op: assert property (p_set_bit_op) else $error("set carry failed");

	property p_setbit;
		@(posedge clock) disable iff (!arst_n)
		isSetBit |=> bitWrite && bitWriteData && bitWriteAddr == $past(bitAddr) && $stable(carry);
	endproperty
	a_setbit: assert property (p_setbit) else $error("set bit failed");

	property p_right_done;
		@(posedge clock) disable iff (!arst_n)
		isRight |=> execDone ##1 (execDone == $past(isRotate || isSetC || isSetBit));
	endproperty
	a_right_done: assert property (p_right_done) else $error("right rotate not one cycle");

	// ----------------------------------------
	// checks: completion and write port
	// ----------------------------------------
	// the write port is shared with the rest of the core, so a stray pulse would corrupt a port bit
	property p_leftc_done;
		@(posedge clock) disable iff (!arst_n)
		isLeftC |=> execDone && !bitWrite;
	endproperty
	a_leftc_done: assert property (p_leftc_done) else $error("left thru carry not one cycle");

	property p_rightc_done;
		@(posedge clock) disable iff (!arst_n)
		isRightC |=> execDone && !bitWrite;
	endproperty
	a_rightc_done: assert property (p_rightc_done) else $error("right thru carry not one cycle");

	property p_plain_nowrite;
		@(posedge clock) disable iff (!arst_n)
		(isLeft || isRight) |=> !bitWrite && !bitWriteData;
	endproperty
	a_plain_nowrite: assert property (p_plain_nowrite) else $error("plain rotate wrote a bit");

	property p_ring_addr;
		@(posedge clock) disable iff (!arst_n)
		(isLeftC || isRightC) |=> $stable(bitWriteAddr) && !bitWriteData;
	endproperty
	a_ring_addr: assert property (p_ring_addr) else $error("carry rotate touched write port");

	property p_set_bit_op_done;
		@(posedge clock) disable iff (!arst_n)
		isSetC |=> execDone && $stable(bitWriteAddr);
	endproperty
	a_set_bit_op_done: assert property (p_set_bit_op_done) else $error("set carry not one cycle");

	property p_setbit_acc;
		@(posedge clock) disable iff (!arst_n)
		isSetBit |=> execDone && $stable(acc);
	endproperty
	a_setbit_acc: assert property (p_setbit_acc) else $error("set bit moved the accumulator");

	property p_write_data;
		@(posedge clock) disable iff (!arst_n)
		bitWriteData == bitWrite;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data not one");

	property p_addr_hold;
		@(posedge clock) disable iff (!arst_n)
		!isSetBit |=> $stable(bitWriteAddr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("write address moved");

	// unknown opcodes belong to other units, so nothing here may move for them
	property p_idle;
		@(posedge clock) disable iff (!arst_n)
		!(isRotate || isSetC || isSetBit) |=> !execDone && !bitWrite && $stable(acc) && $stable(carry);
	endproperty
	a_idle: assert property (p_idle) else $error("state moved without a known opcode");

	property p_write_src;
		@(posedge clock) disable iff (!arst_n)
		bitWrite |-> $past(isSetBit);
	endproperty
	a_write_src: assert property (p_write_src) else $error("write pulse without set bit");

	property p_done_src;
		@(posedge clock) disable iff (!arst_n)
		execDone |-> $past(isRotate || isSetC || isSetBit);
	endproperty
	a_done_src: assert property (p_done_src) else $error("done without an opcode");

	property p_rightc_ring;
		@(posedge clock) disable iff (!arst_n)
		isRightC |=> {acc, carry} == {$past(carry), $past(acc)};
	endproperty
	a_rightc_ring: assert property (p_rightc_ring) else $error("right ring wrong");
endmodule

// *** rot_bitset_pkg.sv ***
// Purpose: shared constants for the accumulator rotate and bit-set unit
// Assumes: 8-bit accumulator, one machine cycle per instruction
// Notes: opcode values are the instruction byte encodings
package rot_bitset_pkg;
	localparam int ACC_WIDTH = 8;
	localparam logic [7:0] OPC_ROTATE_ACC_LEFT = 8'h23;
	localparam logic [7:0] OPC_ROTATE_ACC_LEFT_THRU_CARRY = 8'h33;
	localparam logic [7:0] OPC_ROTATE_ACC_RIGHT = 8'h03;
	localparam logic [7:0] OPC_ROTATE_ACC_RIGHT_THRU_CARRY = 8'h13;
	localparam logic [7:0] OPC_SET_BIT_OP_CARRY = 8'hD3;
	localparam logic [7:0] OPC_SET_BIT_OP_BIT = 8'hD2;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic [7:0] BIT_ADDR_RESET = 8'h00;
endpackage

// *** rot_shift_core.sv ***
// Purpose: combinational rotate of the accumulator, with or without carry
// Assumes: operands valid in the same cycle
// Notes: pure logic, no state
`timescale 1ns/1ns
module rot_shift_core (
	// operands
	input wire logic [7:0] accIn,
	input wire logic carryIn,
	// selection
	input wire logic dirRight,
	input wire logic thruCarry,
	// result
	output logic [7:0] accOut,
	output logic carryOut
);
	wire logic leftFill;
	wire logic rightFill;
	assign leftFill = thruCarry ? carryIn : accIn[7];
	assign rightFill = thruCarry ? carryIn : accIn[0];
	assign accOut = dirRight ? {rightFill, accIn[7:1]} : {accIn[6:0], leftFill};
	assign carryOut = thruCarry ? (dirRight ? accIn[0] : accIn[7]) : carryIn;
endmodule

// *** decoder_model.sv ***
// Purpose: stand-in for the core decoder, one opcode per cycle
// Assumes: the bench places requests on the clock edge
// Notes: the bit address means nothing outside a direct-bit set
`timescale 1ns/1ns
module decoder_model (
	// from bench
	input wire logic reqValid,
	input wire logic [7:0] reqOp,
	input wire logic [7:0] reqAddr,
	// to unit
	output logic execValid,
	output logic [7:0] opcode,
	output logic [7:0] bitAddr
);
	assign execValid = reqValid;
	assign opcode = reqOp;
	// inverted unless a valid 0xD2 direct-bit set is requested, so a stale address can never look right
	assign bitAddr = (reqValid && reqOp == 8'hD2) ? reqAddr : ~reqAddr;
endmodule

// *** test_accumulator_rotate_bitset_unit.sv ***
// Purpose: random rotate and bit-set traffic against a reference model
// Assumes: acc and carry start at zero
// Notes: results are queued at drive time and checked on execDone
`timescale 1ns/1ns
module test_accumulator_rotate_bitset_unit;
	logic clock = 1'b0, arst_n = 1'b0, reqValid = 1'b0, mC = 1'b0;
	logic [7:0] reqOp = 8'h00, reqAddr = 8'h00, mAcc = 8'h00, mAddr = 8'h00;
	logic [7:0] opcode, bitAddr, acc, bitWriteAddr;
	logic execValid, carry, bitWrite, bitWriteData, execDone;
	logic [18:0] q[$];
	logic [18:0] e;
	// last expected state from the model, so quiet cycles are judged against it
	logic [18:0] last = 19'h00000;
	logic [31:0] lfsr = 32'h2501218A;
	logic [7:0] ops[8] = '{8'h23, 8'h33, 8'h03, 8'h13, 8'hD3, 8'hD2, 8'hA5, 8'h13};
	int errors = 0, compares = 0;
	initial forever #10 clock = ~clock;
	decoder_model dec_u (.reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
		.execValid(execValid), .opcode(opcode), .bitAddr(bitAddr));
	accumulator_rotate_bitset_unit dut_u (.clock(clock), .arst_n(arst_n),
		.execValid(execValid), .opcode(opcode), .bitAddr(bitAddr), .acc(acc),
		.carry(carry), .bitWrite(bitWrite), .bitWriteAddr(bitWriteAddr),
		.bitWriteData(bitWriteData), .execDone(execDone));
	function automatic logic [31:0] nxt(input logic [31:0] l);
		return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
	endfunction
	task automatic check(input logic [18:0] got, input logic [18:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic issue(input logic v, input logic [7:0] op, input logic [7:0] ad);
		logic w, k;
		w = 1'b0;
		k = v;
		@(posedge clock);
		reqValid <= v;
		reqOp <= op;
		reqAddr <= ad;
		if (v) begin
			case (op)
				8'h23: mAcc = {mAcc[6:0], mAcc[7]};
				8'h33: {mC, mAcc} = {mAcc, mC};
				8'h03: mAcc = {mAcc[0], mAcc[7:1]};
				8'h13: {mAcc, mC} = {mC, mAcc};
				8'hD3: mC = 1'b1;
				8'hD2: begin
					w = 1'b1;
					mAddr = ad;
				end
				default: k = 1'b0;
			endcase
		end
		if (k)
			q.push_back({mAcc, mC, w, w, mAddr});
	endtask
	// -------------------------------------------
	// result watcher: quiet cycles must hold state
	// -------------------------------------------
	always @(negedge clock) if (arst_n) begin
		e = execDone !== 1'b1 ? {last[18:10], 2'b00, last[7:0]} : q.size() ? q.pop_front() : '1;
		check({acc, carry, bitWrite, bitWriteData, bitWriteAddr}, e);
		last = e;
	end
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		check({acc, carry, bitWrite, bitWriteData, bitWriteAddr}, 19'h0);
		// reset leaves acc zero, so carry is the only way to seed bits
		issue(1'b1, 8'hD3, 8'h00);
		for (int i = 0; i < 400; i++) begin
			lfsr = nxt(lfsr);
			issue(lfsr[3], ops[lfsr[6:4]], lfsr[15:8]);
		end
		issue(1'b0, 8'h00, 8'h00);
		repeat (3) @(posedge clock);
		check(19'(q.size()), 19'h0);
		$display("random test done");
		end_of_test();
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
